// file: rtl/ddr2_burst_pkg.sv
// Constants shared by the DDR2 burst and precharge logic
// Function
// - Read auto precharge closes row after burst
// - First read data after posted plus CAS latency
// - Later read elements follow on each clock edge
// - Strobe driven low before first read, released after last
// - Data lines released after read burst ends
// - Bank, column, A10 auto precharge from command
// - Mask bit high discards that write byte
// - Write latency is read latency minus one
// - Write elements captured on successive strobe edges
// - After write burst, extra input data ignored
// - Eight element write cut only by write
// - Write recovery starts at end of data
// - Precharge accepted on idle bank, last restarts
// - A10 selects all banks or one bank
package ddr2_burst_pkg;
	localparam int BANKS         = 8;
	localparam int BANK_W        = 3;
	localparam int ADDR_W        = 14;
	localparam int COL_W         = 10;
	localparam int WORD_W        = COL_W - 1;
	localparam int AP_BIT        = 10;
	localparam int CL_MIN        = 4;
	localparam int CL_MAX        = 6;
	localparam int AL_MAX        = 4;
	localparam int PIPE_DEPTH    = 10;
	// Pipe entry layout: read, write, bank, column, auto precharge
	localparam int ENT_AP        = 0;
	localparam int ENT_COL       = 1;
	localparam int ENT_BA        = ENT_COL + COL_W;
	localparam int ENT_WR        = ENT_BA + BANK_W;
	localparam int ENT_RD        = ENT_WR + 1;
	localparam int ENT_W         = ENT_RD + 1;
	// Timing in ns and derived system clock counts
	localparam int SYS_PERIOD_NS = 8;
	localparam int TRP_NS        = 15;
	localparam int ALL_BANK_PRECHARGE_TIME_NS       = 20;
	localparam int TWR_NS        = 15;
	localparam int TRP_CYC       = (TRP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int ALL_BANK_PRECHARGE_TIME_CYC      = (ALL_BANK_PRECHARGE_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int TWR_CYC       = (TWR_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int TMR_W         = 6;
	localparam int BLH4          = 2;
	localparam int BLH8          = 4;
endpackage : ddr2_burst_pkg

// file: rtl/ddr2_beat_store.sv
// Byte-maskable array holding one clock of DDR data per word
`timescale 1ns/1ps
module ddr2_beat_store #(
	parameter int AW = 12,
	parameter int DW = 16
) (
	input  wire logic            clk,
	input  wire logic [AW-1:0]   rd_addr,
	output logic      [DW-1:0]   rd_data_q,
	input  wire logic            wr_en,
	input  wire logic [AW-1:0]   wr_addr,
	input  wire logic [DW-1:0]   wr_data,
	input  wire logic [DW/8-1:0] wr_be
);
	logic [DW-1:0] mem_q [2**AW];

	if (DW < 8 || DW % 8 != 0) begin : g_chk
		$error("store width must be a whole number of bytes");
	end

	// ************************************************************
	// Read register and per-byte write lanes in one process
	// ************************************************************
	always_ff @(posedge clk) begin
		rd_data_q <= mem_q[rd_addr];
		for (int i = 0; i < DW / 8; i++) begin
			if (wr_en && wr_be[i]) begin
				mem_q[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
			end
		end
	end
endmodule : ddr2_beat_store

// file: rtl/ddr2_burst_precharge_ops.sv
// DDR2 read/write burst engine with bank precharge timing
`timescale 1ns/1ps
module ddr2_burst_precharge_ops
	import ddr2_burst_pkg::*;
#(
	parameter int DW = 8
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic [2:0]        posted_extra_latency,
	input  wire logic [2:0]        column_access_latency,
	input  wire logic              burst_length_eight,
	output logic [BANKS-1:0]       bank_busy,
	input  wire logic              ck_link,
	input  wire logic              cs_n,
	input  wire logic              ras_n,
	input  wire logic              cas_n,
	input  wire logic              we_n,
	input  wire logic [BANK_W-1:0] ba_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DW-1:0]     dq_rise_in,
	input  wire logic [DW-1:0]     dq_fall_in,
	input  wire logic [DW/8-1:0]   dm_rise_in,
	input  wire logic [DW/8-1:0]   dm_fall_in,
	input  wire logic              dqs_in,
	output logic [DW-1:0]          dq_rise_out,
	output logic [DW-1:0]          dq_fall_out,
	output logic                   dq_oe_n,
	output logic                   dqs_out,
	output logic                   dqs_oe_n,
	output logic [BANKS-1:0]       row_open
);
	localparam int NB = DW / 8;
	localparam int AW = BANK_W + WORD_W;

	if (DW < 8 || DW % 8 != 0) begin : g_chk
		$error("data width must be a whole number of bytes");
	end

	// ************************************************************
	// Link reset and settings synchronisers
	// ************************************************************
	logic       lrst_s1_q;
	logic       link_rst_n_q;
	logic [6:0] cfg_s1_q;
	logic [6:0] cfg_s2_q;

	always_ff @(posedge ck_link or negedge rst_n) begin
		if (!rst_n) begin
			lrst_s1_q    <= 1'b0;
			link_rst_n_q <= 1'b0;
		end else begin
			lrst_s1_q    <= 1'b1;
			link_rst_n_q <= lrst_s1_q;
		end
	end

	always_ff @(posedge ck_link or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			cfg_s1_q <= 7'h00;
			cfg_s2_q <= 7'h00;
		end else begin
			cfg_s1_q <= {burst_length_eight, posted_extra_latency, column_access_latency};
			cfg_s2_q <= cfg_s1_q;
		end
	end

	// Out-of-range latency settings are clamped
	wire [2:0] cl_raw = cfg_s2_q[2:0];
	wire [2:0] al_raw = cfg_s2_q[5:3];
	wire       bl8    = cfg_s2_q[6];
	wire [3:0] cl_eff = (cl_raw < 3'(CL_MIN)) ? 4'(CL_MIN) :
	                    (cl_raw > 3'(CL_MAX)) ? 4'(CL_MAX) : {1'b0, cl_raw};
	wire [3:0] al_eff = (al_raw > 3'(AL_MAX)) ? 4'(AL_MAX) : {1'b0, al_raw};
	wire [3:0] rl     = al_eff + cl_eff;
	wire [3:0] tap    = rl - 4'h2;
	wire [3:0] bl_half = bl8 ? 4'(BLH8) : 4'(BLH4);

	// ************************************************************
	// Command decode
	// ************************************************************
	wire sel    = !cs_n;
	wire is_act = sel && !ras_n && cas_n && we_n;
	wire is_rd  = sel && ras_n && !cas_n && we_n;
	wire is_wr  = sel && ras_n && !cas_n && !we_n;
	wire is_pre = sel && !ras_n && cas_n && !we_n;
	wire a10    = addr_in[AP_BIT];
	wire [ENT_W-1:0] ent_in = (is_rd || is_wr) ?
		{is_rd, is_wr, ba_in, addr_in[COL_W-1:0], a10} : '0;

	// ************************************************************
	// Latency pipe, tapped at read latency minus two
	// ************************************************************
	logic [ENT_W-1:0] pipe_q [PIPE_DEPTH];
	logic [ENT_W-1:0] pipe_d [PIPE_DEPTH];

	for (genvar g = 0; g < PIPE_DEPTH; g++) begin : g_pipe
		if (g == 0) begin : g_head
			assign pipe_d[g] = ent_in;
		end else begin : g_body
			assign pipe_d[g] = pipe_q[g-1];
		end
		always_ff @(posedge ck_link or negedge link_rst_n_q) begin
			if (!link_rst_n_q) begin
				pipe_q[g] <= '0;
			end else begin
				pipe_q[g] <= pipe_d[g];
			end
		end
	end

	wire [ENT_W-1:0]  tap_ent  = pipe_q[tap];
	wire              rd_start = tap_ent[ENT_RD];
	wire              wr_start = tap_ent[ENT_WR];
	wire [WORD_W-1:0] tap_word = tap_ent[ENT_COL+1 +: WORD_W];

	function automatic logic [WORD_W-1:0] next_word(input logic [WORD_W-1:0] w,
	                                                input logic              eight);
		logic [WORD_W-1:0] n;
		n = w;
		if (eight) begin
			n[1:0] = w[1:0] + 2'h1;
		end else begin
			n[0] = !w[0];
		end
		return n;
	endfunction : next_word

	// ************************************************************
	// Read burst engine
	// ************************************************************
	logic [3:0]        rd_left_q;
	logic [WORD_W-1:0] rd_word_q;
	logic [BANK_W-1:0] rd_ba_q;
	logic              rd_ap_q;
	logic              rd_issue_q;
	logic [2*DW-1:0]   rd_data;

	wire               rd_issue  = rd_start || (rd_left_q != 4'h0);
	wire [WORD_W-1:0]  rd_word   = rd_start ? tap_word : rd_word_q;
	wire [BANK_W-1:0]  rd_bank   = rd_start ? tap_ent[ENT_BA +: BANK_W] : rd_ba_q;
	wire               rd_last   = !rd_start && (rd_left_q == 4'h1);
	wire               rd_ap_end = rd_last && rd_ap_q;

	always_ff @(posedge ck_link or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			rd_left_q  <= 4'h0;
			rd_word_q  <= '0;
			rd_ba_q    <= '0;
			rd_ap_q    <= 1'b0;
			rd_issue_q <= 1'b0;
		end else begin
			rd_left_q  <= rd_start ? bl_half - 4'h1 : rd_left_q - 4'(rd_left_q != 4'h0);
			rd_word_q  <= next_word(rd_word, bl8);
			rd_ba_q    <= rd_bank;
			rd_ap_q    <= rd_start ? tap_ent[ENT_AP] : rd_ap_q;
			rd_issue_q <= rd_issue;
		end
	end

	// ************************************************************
	// Read pins: preamble, data on both halves, release with no postamble
	// ************************************************************
	logic [DW-1:0] dq_rise_q;
	logic [DW-1:0] dq_fall_q;
	logic          dq_oe_n_q;
	logic          dqs_q;
	logic          dqs_oe_n_q;

	always_ff @(posedge ck_link or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			dq_rise_q  <= '0;
			dq_fall_q  <= '0;
			dq_oe_n_q  <= 1'b1;
			dqs_q      <= 1'b0;
			dqs_oe_n_q <= 1'b1;
		end else begin
			dq_rise_q  <= rd_issue_q ? rd_data[DW-1:0] : '0;
			dq_fall_q  <= rd_issue_q ? rd_data[2*DW-1:DW] : '0;
			dq_oe_n_q  <= !rd_issue_q;
			dqs_q      <= rd_issue_q;
			dqs_oe_n_q <= !(rd_issue || rd_issue_q);
		end
	end

	// ************************************************************
	// Write burst engine
	// ************************************************************
	logic [3:0]        wr_left_q;
	logic [WORD_W-1:0] wr_word_q;
	logic [BANK_W-1:0] wr_ba_q;
	logic              wr_ap_q;

	wire               wr_busy   = wr_left_q != 4'h0;
	wire               mem_we    = wr_busy && dqs_in;
	wire [2*NB-1:0]    mem_be    = ~{dm_fall_in, dm_rise_in};
	wire               wr_ap_end = (wr_left_q == 4'h1) && wr_ap_q;

	always_ff @(posedge ck_link or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			wr_left_q <= 4'h0;
			wr_word_q <= '0;
			wr_ba_q   <= '0;
			wr_ap_q   <= 1'b0;
		end else if (wr_start) begin
			wr_left_q <= bl_half;
			wr_word_q <= tap_word;
			wr_ba_q   <= tap_ent[ENT_BA +: BANK_W];
			wr_ap_q   <= tap_ent[ENT_AP];
		end else if (wr_busy) begin
			wr_left_q <= wr_left_q - 4'h1;
			wr_word_q <= next_word(wr_word_q, bl8);
		end
	end

	ddr2_beat_store #(
		.AW (AW),
		.DW (2 * DW)
	) u_store (
		.clk       (ck_link),
		.rd_addr   ({rd_bank, rd_word}),
		.rd_data_q (rd_data),
		.wr_en     (mem_we),
		.wr_addr   ({wr_ba_q, wr_word_q}),
		.wr_data   ({dq_fall_in, dq_rise_in}),
		.wr_be     (mem_be)
	);

	// ************************************************************
	// Row state and precharge events toward the system clock
	// ************************************************************
	logic [BANKS-1:0] row_open_q;
	logic [BANKS-1:0] pre_tgl_q;
	logic [BANKS-1:0] wrp_tgl_q;
	logic             all_tgl_q;
	logic [BANKS-1:0] ev_pre_l;
	logic [BANKS-1:0] ev_wrp_l;
	logic [BANKS-1:0] ev_act_l;
	wire              ev_all_l = is_pre && a10;

	for (genvar b = 0; b < BANKS; b++) begin : g_lbank
		assign ev_pre_l[b] = (is_pre && !a10 && ba_in == BANK_W'(b)) ||
		                     (rd_ap_end && rd_ba_q == BANK_W'(b));
		assign ev_wrp_l[b] = wr_ap_end && wr_ba_q == BANK_W'(b);
		assign ev_act_l[b] = is_act && ba_in == BANK_W'(b);
		always_ff @(posedge ck_link or negedge link_rst_n_q) begin
			if (!link_rst_n_q) begin
				row_open_q[b] <= 1'b0;
				pre_tgl_q[b]  <= 1'b0;
				wrp_tgl_q[b]  <= 1'b0;
			end else begin
				row_open_q[b] <= ev_act_l[b] ||
				                 (row_open_q[b] && !ev_pre_l[b] && !ev_wrp_l[b] && !ev_all_l);
				pre_tgl_q[b]  <= pre_tgl_q[b] ^ ev_pre_l[b];
				wrp_tgl_q[b]  <= wrp_tgl_q[b] ^ ev_wrp_l[b];
			end
		end
	end

	always_ff @(posedge ck_link or negedge link_rst_n_q) begin
		if (!link_rst_n_q) begin
			all_tgl_q <= 1'b0;
		end else begin
			all_tgl_q <= all_tgl_q ^ ev_all_l;
		end
	end

	// ************************************************************
	// System clock precharge timers per bank
	// ************************************************************
	logic [2:0]       all_sy_q;
	logic [BANKS-1:0] busy_q;
	wire              ev_all_s = all_sy_q[1] ^ all_sy_q[2];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			all_sy_q <= 3'h0;
		end else begin
			all_sy_q <= {all_sy_q[1:0], all_tgl_q};
		end
	end

	for (genvar b = 0; b < BANKS; b++) begin : g_sbank
		logic [2:0]       pre_sy_q;
		logic [2:0]       wrp_sy_q;
		logic [TMR_W-1:0] tmr_q;
		wire              ev_pre = pre_sy_q[1] ^ pre_sy_q[2];
		wire              ev_wrp = wrp_sy_q[1] ^ wrp_sy_q[2];
		wire [TMR_W-1:0]  tmr_d  = ev_wrp ? TMR_W'(TWR_CYC + TRP_CYC) :
		                           ev_all_s ? TMR_W'(ALL_BANK_PRECHARGE_TIME_CYC) :
		                           ev_pre ? TMR_W'(TRP_CYC) :
		                           tmr_q - TMR_W'(tmr_q != '0);

		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				pre_sy_q <= 3'h0;
				wrp_sy_q <= 3'h0;
				tmr_q    <= '0;
				busy_q[b] <= 1'b0;
			end else begin
				pre_sy_q <= {pre_sy_q[1:0], pre_tgl_q[b]};
				wrp_sy_q <= {wrp_sy_q[1:0], wrp_tgl_q[b]};
				tmr_q    <= tmr_d;
				busy_q[b] <= tmr_d != '0;
			end
		end

		pre_one_t_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
			ev_pre && !ev_all_s && !ev_wrp |=> tmr_q == TMR_W'(TRP_CYC) && busy_q[b])
			else $error("single bank precharge time not loaded");
		wr_recov_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
			ev_wrp |=> tmr_q == TMR_W'(TWR_CYC + TRP_CYC))
			else $error("write recovery not started at burst end");
		pre_all_t_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
			ev_all_s && !ev_wrp |=> tmr_q == TMR_W'(ALL_BANK_PRECHARGE_TIME_CYC))
			else $error("all bank precharge time not loaded");
	end

	assign dq_rise_out = dq_rise_q;
	assign dq_fall_out = dq_fall_q;
	assign dq_oe_n     = dq_oe_n_q;
	assign dqs_out     = dqs_q;
	assign dqs_oe_n    = dqs_oe_n_q;
	assign row_open    = row_open_q;
	assign bank_busy   = busy_q;

	// ************************************************************
	// Checks
	// ************************************************************
	rd_first_a: assert property (@(posedge ck_link) disable iff (!link_rst_n_q)
		rd_start && !rd_issue_q |-> ##2 !dq_oe_n_q && dqs_q)
		else $error("first read element not at read latency");
	rd_beats_a: assert property (@(posedge ck_link) disable iff (!link_rst_n_q)
		rd_start && bl8 |-> ##2 (!dq_oe_n_q && dqs_q)[*4])
		else $error("read burst elements not consecutive");
	rd_pre_a: assert property (@(posedge ck_link) disable iff (!link_rst_n_q)
		rd_start && !rd_issue_q |=> !dqs_oe_n_q && !dqs_q && dq_oe_n_q)
		else $error("read preamble missing");
	rd_release_a: assert property (@(posedge ck_link) disable iff (!link_rst_n_q)
		$fell(rd_issue_q) && !rd_issue |=> dq_oe_n_q && dqs_oe_n_q)
		else $error("data lines not released after read");
	rd_autopre_a: assert property (@(posedge ck_link) disable iff (!link_rst_n_q)
		rd_ap_end && !is_act |=> !row_open_q[$past(rd_ba_q)])
		else $error("read auto precharge left row open");
	wr_mask_a: assert property (@(posedge ck_link) disable iff (!link_rst_n_q)
		mem_we && (&dm_rise_in) && (&dm_fall_in) |-> mem_be == '0)
		else $error("masked write byte stored");
	wr_start_a: assert property (@(posedge ck_link) disable iff (!link_rst_n_q)
		wr_start |=> wr_left_q == bl_half ##1 wr_left_q == bl_half - 4'h1)
		else $error("write burst capture not started");
	wr_idle_a: assert property (@(posedge ck_link) disable iff (!link_rst_n_q)
		!wr_busy |-> !mem_we && dq_oe_n_q == !$past(rd_issue_q))
		else $error("write data taken outside burst");
	pre_all_a: assert property (@(posedge ck_link) disable iff (!link_rst_n_q)
		is_pre && a10 && !is_act |=> row_open_q == '0)
		else $error("precharge all left a row open");
	pre_one_a: assert property (@(posedge ck_link) disable iff (!link_rst_n_q)
		is_pre && !a10 |=> !row_open_q[$past(ba_in)])
		else $error("single bank precharge missed its bank");

	rd_gapless_c: cover property (@(posedge ck_link) disable iff (!link_rst_n_q)
		rd_start && rd_issue_q);
	wr_trunc_c: cover property (@(posedge ck_link) disable iff (!link_rst_n_q)
		wr_start && wr_left_q > 4'h1);
	pre_all_c: cover property (@(posedge ck_link) disable iff (!link_rst_n_q)
		is_pre && a10 && (row_open_q != '0));
	wr_autopre_c: cover property (@(posedge ck_link) disable iff (!link_rst_n_q)
		wr_ap_end);
endmodule : ddr2_burst_precharge_ops

// file: verif/ddr2_ctl_model.sv
// Behavioural DDR2 controller driving commands and write data on the link
`timescale 1ns/1ps
module ddr2_ctl_model
	import ddr2_burst_pkg::*;
#(
	parameter int DW = 8
) (
	input  wire logic          ck_link,
	output logic               cs_n,
	output logic               ras_n,
	output logic               cas_n,
	output logic               we_n,
	output logic [BANK_W-1:0]  ba_in,
	output logic [ADDR_W-1:0]  addr_in,
	output logic [DW-1:0]      dq_rise_in,
	output logic [DW-1:0]      dq_fall_in,
	output logic [DW/8-1:0]    dm_rise_in,
	output logic [DW/8-1:0]    dm_fall_in,
	output logic               dqs_in
);
	initial begin
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'b111;
		ba_in = '0;
		addr_in = '0;
		dq_rise_in = '0;
		dq_fall_in = '0;
		dm_rise_in = '0;
		dm_fall_in = '0;
		dqs_in = 1'b0;
	end

	// One command for one link clock, then deselect with scrambled lines
	task automatic issue(input logic [2:0] rcw, input logic [BANK_W-1:0] ba,
			input logic [ADDR_W-1:0] a);
		@(posedge ck_link);
		cs_n <= 1'b0;
		{ras_n, cas_n, we_n} <= rcw;
		ba_in <= ba;
		addr_in <= a;
		@(posedge ck_link);
		cs_n <= 1'b1;
		ba_in <= ~ba;
		addr_in <= ~a;
	endtask : issue

	// Four element burst; d is {word1, word0}, each word {fall, rise}
	task automatic burst(input int wl, input logic [4*DW-1:0] d, input logic [1:0] m,
			input bit late);
		int i;
		repeat (wl) @(posedge ck_link);
		for (i = 0; i < 2; i++) begin
			dq_rise_in <= d[i*2*DW +: DW];
			dq_fall_in <= d[i*2*DW+DW +: DW];
			dm_rise_in <= '0;
			dm_fall_in <= {(DW/8){m[i]}};
			dqs_in     <= 1'b1;
			@(posedge ck_link);
		end
		// Stray strobe after the burst only when asked for
		dqs_in     <= late;
		dq_rise_in <= ~dq_rise_in;
		dq_fall_in <= ~dq_fall_in;
		@(posedge ck_link);
		dqs_in     <= 1'b0;
	endtask : burst
endmodule : ddr2_ctl_model

// file: verif/test_ddr2_burst_precharge_ops.sv
// Self-checking bench for the DDR2 burst and precharge engine
`timescale 1ns/1ps
module test_ddr2_burst_precharge_ops;
	import ddr2_burst_pkg::*;
	localparam int DW = 8;
	logic                clk_sys, rst_n, ck_link, burst_length_eight;
	logic [2:0]          posted_extra_latency, column_access_latency;
	logic [BANKS-1:0]    bank_busy, row_open;
	logic                cs_n, ras_n, cas_n, we_n, dqs_in;
	logic [BANK_W-1:0]   ba_in;
	logic [ADDR_W-1:0]   addr_in;
	logic [DW-1:0]       dq_rise_in, dq_fall_in, dq_rise_out, dq_fall_out;
	logic [DW/8-1:0]     dm_rise_in, dm_fall_in;
	logic                dq_oe_n, dqs_out, dqs_oe_n;
	int                  fails = 0;
	int                  n_tests = 0;

	ddr2_burst_precharge_ops #(.DW(DW)) u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .posted_extra_latency(posted_extra_latency),
		.column_access_latency(column_access_latency), .burst_length_eight(burst_length_eight),
		.bank_busy(bank_busy), .ck_link(ck_link), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .ba_in(ba_in), .addr_in(addr_in), .dq_rise_in(dq_rise_in),
		.dq_fall_in(dq_fall_in), .dm_rise_in(dm_rise_in), .dm_fall_in(dm_fall_in),
		.dqs_in(dqs_in), .dq_rise_out(dq_rise_out), .dq_fall_out(dq_fall_out),
		.dq_oe_n(dq_oe_n), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .row_open(row_open));

	ddr2_ctl_model #(.DW(DW)) u_ctl (
		.ck_link(ck_link), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.ba_in(ba_in), .addr_in(addr_in), .dq_rise_in(dq_rise_in), .dq_fall_in(dq_fall_in),
		.dm_rise_in(dm_rise_in), .dm_fall_in(dm_fall_in), .dqs_in(dqs_in));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Link clock, phase unrelated to the system clock
	initial begin
		ck_link = 1'b0;
		#3;
		forever #32 ck_link = ~ck_link;
	end

	//****************************************
	// Compare and support tasks
	//****************************************
	task automatic chk_flag(input logic [BANKS-1:0] got, input logic [BANKS-1:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: flag got %h expected %h", $time, got, exp);
		end
	endtask : chk_flag

	task automatic chk_word(input logic [2*DW-1:0] got, input logic [2*DW-1:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: data got %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_count(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			fails++;
			$display("Error at %0t: busy cycles %0d expected %0d", $time, got, exp);
		end
	endtask : chk_count

	task automatic wrap_up;
		$display("Counts: %0d compares, %0d mismatches", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	task automatic set_lat(input logic [2:0] al, input logic [2:0] cl);
		@(posedge clk_sys);
		posted_extra_latency  <= al;
		column_access_latency <= cl;
		repeat (4) @(posedge ck_link);
	endtask : set_lat

	// Counts system cycles with any bank busy, and which banks were busy
	task automatic watch_busy(output int cnt, output logic [BANKS-1:0] seen);
		cnt = 0;
		seen = '0;
		repeat (96) begin
			@(posedge clk_sys);
			#1;
			if (bank_busy !== '0)
				cnt++;
			seen |= bank_busy;
		end
	endtask : watch_busy

	// Read at column 0 and follow strobe, enables and data edge by edge
	task automatic rd_check(input logic [BANK_W-1:0] ba, input bit ap, input int rl,
			input logic [2*DW-1:0] w0, input logic [2*DW-1:0] w1);
		int   k;
		logic act;
		u_ctl.issue(3'b101, ba, {3'b000, ap, 10'h000});
		for (k = 0; k <= rl + 2; k++) begin
			@(negedge ck_link);
			act = (k >= rl) && (k < rl + 2);
			chk_flag(dqs_oe_n, !(act || k == rl - 1));
			chk_flag(dq_oe_n, !act);
			if (k == rl - 1)
				chk_flag(dqs_out, 1'b0);
			if (act)
				chk_flag(dqs_out, 1'b1);
			if (act)
				chk_word({dq_fall_out, dq_rise_out}, (k == rl) ? w0 : w1);
		end
	endtask : rd_check

	//****************************************
	// Scenarios
	//****************************************
	task automatic t_reset;
		chk_flag(dq_oe_n, 1'b1);
		chk_flag(dqs_oe_n, 1'b1);
		chk_flag(row_open, 8'h00);
		chk_flag(bank_busy, 8'h00);
		$display("Test reset done");
	endtask : t_reset

	task automatic t_write_read;
		int               cnt;
		logic [BANKS-1:0] seen;
		u_ctl.issue(3'b011, 3'h1, 14'h0000);
		repeat (2) @(posedge ck_link);
		chk_flag(row_open, 8'h02);
		u_ctl.issue(3'b100, 3'h1, 14'h0000);
		u_ctl.burst(4, 32'h4433_2211, 2'b00, 1'b0);
		repeat (3) @(posedge ck_link);
		u_ctl.issue(3'b100, 3'h1, 14'h0400);
		fork
			u_ctl.burst(4, 32'h8877_6655, 2'b10, 1'b1);
			watch_busy(cnt, seen);
		join
		chk_count(cnt, TWR_CYC + TRP_CYC);
		chk_flag(seen, 8'h02);
		u_ctl.issue(3'b011, 3'h1, 14'h0000);
		repeat (3) @(posedge ck_link);
		rd_check(3'h1, 1'b0, 5, 16'h6655, 16'h4477);
		chk_flag(row_open, 8'h02);
		$display("Test write_read done");
	endtask : t_write_read

	task automatic t_read_ap;
		set_lat(3'h2, 3'h4);
		rd_check(3'h1, 1'b1, 6, 16'h6655, 16'h4477);
		repeat (2) @(posedge ck_link);
		chk_flag(row_open, 8'h00);
		set_lat(3'h0, 3'h5);
		$display("Test read_ap done");
	endtask : t_read_ap

	// Two reads one whole burst apart, then one eight element read
	task automatic t_read_gap;
		int k;
		u_ctl.issue(3'b101, 3'h1, 14'h0000);
		u_ctl.issue(3'b101, 3'h1, 14'h0002);
		for (k = 2; k <= 9; k++) begin
			@(negedge ck_link);
			chk_flag(dq_oe_n, !(k >= 5 && k < 9));
			if (k >= 5 && k < 9)
				chk_word({dq_fall_out, dq_rise_out}, (k == 5 || k == 8) ? 16'h6655 : 16'h4477);
		end
		@(posedge clk_sys);
		burst_length_eight <= 1'b1;
		repeat (4) @(posedge ck_link);
		u_ctl.issue(3'b101, 3'h1, 14'h0000);
		for (k = 0; k <= 9; k++) begin
			@(negedge ck_link);
			chk_flag(dq_oe_n, !(k >= 5 && k < 9));
			if (k == 5 || k == 6)
				chk_word({dq_fall_out, dq_rise_out}, (k == 5) ? 16'h6655 : 16'h4477);
		end
		@(posedge clk_sys);
		burst_length_eight <= 1'b0;
		repeat (4) @(posedge ck_link);
		$display("Test read_gap done");
	endtask : t_read_gap

	task automatic t_precharge;
		int               cnt;
		logic [BANKS-1:0] seen;
		u_ctl.issue(3'b011, 3'h2, 14'h0000);
		u_ctl.issue(3'b011, 3'h3, 14'h0000);
		u_ctl.issue(3'b010, 3'h2, 14'h0000);
		watch_busy(cnt, seen);
		chk_count(cnt, TRP_CYC);
		chk_flag(seen, 8'h04);
		chk_flag(row_open, 8'h08);
		u_ctl.issue(3'b010, 3'h2, 14'h0400);
		watch_busy(cnt, seen);
		chk_count(cnt, ALL_BANK_PRECHARGE_TIME_CYC);
		chk_flag(seen, 8'hFF);
		chk_flag(row_open, 8'h00);
		$display("Test precharge done");
	endtask : t_precharge

	initial begin
		rst_n = 1'b0;
		posted_extra_latency = 3'h0;
		column_access_latency = 3'h5;
		burst_length_eight = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (8) @(posedge ck_link);
		t_reset;
		t_write_read;
		t_read_gap;
		t_read_ap;
		t_precharge;
		wrap_up;
	end

	// Whole run needs well under 20 us
	initial begin
		#200000;
		fails++;
		wrap_up;
	end
endmodule : test_ddr2_burst_precharge_ops
